// ### rtl/i2c_ctl_regs.vh
// Register offsets, field positions, reset values and timing counts of the two-wire controller.
// Assumes inclusion by bare name from the design file; holds definitions only.
`ifndef I2C_CTL_REGS_VH
`define I2C_CTL_REGS_VH

// ----------------------------------------
// Register byte offsets on the APB
// ----------------------------------------
`define OFS_SHIFT 8'h00
`define OFS_ADDR 8'h04
`define OFS_CLKCTL 8'h08
`define OFS_CTL 8'h0C
`define OFS_STATUS 8'h10
`define OFS_TXBUF 8'h14

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_BYTE 8'h00
`define RST_STATUS 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CC_FAST 5
`define CC_ACKLVL 6
`define CC_ACKCLK 7
`define CT_ESO 3
`define CT_ALS 4
`define CT_TEN 5
`define ST_PIN 4
`define ST_BB 5
`define ST_TRX 6
`define ST_MST 7

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_PS 5000
`define T_HOLD_STD_NS 4800
`define T_HOLD_HS_NS 2300
`define T_SETUP_STD_NS 5600
`define T_SETUP_HS_NS 2100
`define C_HOLD_STD ((`T_HOLD_STD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define C_HOLD_HS ((`T_HOLD_HS_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define C_SETUP_STD ((`T_SETUP_STD_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define C_SETUP_HS ((`T_SETUP_HS_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define SCL_SH_STD 6
`define SCL_SH_HS 4

`endif

// ### rtl/multi_master_i2c_regs.v
// Multi-master two-wire serial controller with its register file on APB.
// Assumes open-drain SDA and SCL resolved outside; pins are asynchronous to CLK.
//
// Contract
// [RULE1] Own 7-bit address sits in bits 7:1 and is compared in both formats.
// [RULE2] Clock-control bit 5 picks standard (0) or high-speed (1) SCL timing.
// [RULE3] Ack level 0 pulls SDA low in the ack clock; 1 leaves it high.
// [RULE4] Address byte with ack level 0: ack on match, no ack on mismatch.
// [RULE5] Ack clock enable adds an ack clock per byte; transmitter releases and samples.
// [RULE6] Software must not write clock control mid-transfer; it resets the clock generator.
// [RULE7] Bit counter sets bits of next byte; request raised when they are moved.
// [RULE8] START clears the bit counter; address bytes are always eight bits.
// [RULE9] Bit counter 111 cannot wait for STOP or START.
// [RULE10] Disabled: pins float, byte-done set, busy and lost cleared, data writes ignored.
// [RULE11] Addressed format proceeds only on match or general call; free format skips it.
// [RULE12] 7-bit compares upper seven bits; 10-bit compares all eight.
// [RULE13] Status bits 0-3 and 5 read-only; 4, 6 and 7 writable.
// [RULE14] Last bit captures ack or final data bit; data writes clear it.
// [RULE15] General-call flag set on address 00 as slave; cleared on STOP or START.
// [RULE16] 7-bit slave: match flag set on upper-seven match or general call.
// [RULE17] 10-bit slave: match flag set when first byte equals all eight bits.
// [RULE18] Lost arbitration sets the lost flag, clears direction, role after the byte.
// [RULE19] Lost during address send drops into reception to catch own address.
// [RULE20] Shift register sends MSB first, shifting left, receiving into bit 0.
// [RULE21] Byte-done falls after each byte with a request; SCL held low meanwhile.
// [RULE22] Five-bit divider field sets the SCL rate from the bus clock.
// [RULE23] Fields reset to zero unless stated otherwise.
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "i2c_ctl_regs.vh"

module multi_master_i2c_regs (
  input wire CLK,
  input wire NRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output wire PREADY,
  output wire PSLVERR,
  input wire SCL_IN,
  output wire SCL_OUT,
  output reg SCL_OE,
  input wire SDA_IN,
  output wire SDA_OUT,
  output reg SDA_OE,
  output reg IRQ
);

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam integer HOLD_STD = `C_HOLD_STD;
  localparam integer HOLD_HS = `C_HOLD_HS;
  localparam integer SETUP_STD = `C_SETUP_STD;
  localparam integer SETUP_HS = `C_SETUP_HS;
  localparam [2:0] G_IDLE = 3'd0;
  localparam [2:0] G_START = 3'd1;
  localparam [2:0] G_STOP1 = 3'd2;
  localparam [2:0] G_STOP2 = 3'd3;

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] shift_reg;
  reg [7:0] own_address_reg;
  reg [7:0] serial_clock_control_reg;
  reg [7:0] transfer_control_reg;
  reg last_received_bit, broadcast_hit_flag, own_address_match_flag;
  reg arbitration_lost_flag, bus_busy_flag, byte_done_request;
  reg transfer_direction, controller_role;
  reg [3:0] bit_idx;
  reg addr_phase, active, done_pend, quiet, ack_low, data_low;
  reg m_run, scl_rel;
  reg [2:0] gen_state;
  reg [15:0] cnt;
  reg scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;

  wire interface_enable = transfer_control_reg[`CT_ESO];
  wire free_format_select = transfer_control_reg[`CT_ALS];
  wire ten_bit_address_select = transfer_control_reg[`CT_TEN];
  wire [2:0] bits_per_transfer_count = transfer_control_reg[2:0];
  wire high_speed_select = serial_clock_control_reg[`CC_FAST];
  wire acknowledge_drive_level = serial_clock_control_reg[`CC_ACKLVL];
  wire acknowledge_clock_enable = serial_clock_control_reg[`CC_ACKCLK];
  wire [4:0] scl_divider_field = serial_clock_control_reg[4:0];
  wire [7:0] status_word = {controller_role, transfer_direction, bus_busy_flag,
    byte_done_request, arbitration_lost_flag, own_address_match_flag,
    broadcast_hit_flag, last_received_bit};

  // ----------------------------------------
  // APB slave: zero wait states
  // ----------------------------------------
  wire mapped = (PADDR == `OFS_SHIFT) || (PADDR == `OFS_ADDR) || (PADDR == `OFS_CLKCTL) ||
    (PADDR == `OFS_CTL) || (PADDR == `OFS_STATUS) || (PADDR == `OFS_TXBUF);
  wire wr = PSEL & PENABLE & PWRITE & mapped;
  wire [7:0] wd = PWDATA[7:0];
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~mapped;
  wire wr_shift = wr & (PADDR == `OFS_SHIFT) & interface_enable; // [RULE10]
  wire wr_txbuf = wr & (PADDR == `OFS_TXBUF) & interface_enable; // [RULE10]
  wire wr_data = wr_shift | wr_txbuf;
  wire wr_status = wr & (PADDR == `OFS_STATUS);

  always @(posedge CLK) begin
    if (!NRST) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL & ~PENABLE & ~PWRITE) begin
      case (PADDR)
        `OFS_SHIFT: PRDATA <= {24'h000000, shift_reg};
        `OFS_ADDR: PRDATA <= {24'h000000, own_address_reg};
        `OFS_CLKCTL: PRDATA <= {24'h000000, serial_clock_control_reg};
        `OFS_CTL: PRDATA <= {24'h000000, transfer_control_reg};
        `OFS_STATUS: PRDATA <= {24'h000000, status_word}; // [RULE13]
        default: PRDATA <= 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------
  // Pin synchronisers and bus conditions
  // ----------------------------------------
  always @(posedge CLK) begin
    if (!NRST) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= SCL_IN;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= SDA_IN;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  // A counter value of 111 blinds the condition detector, so software must avoid it
  // whenever a STOP or repeated START may arrive.
  wire det_en = interface_enable & (bits_per_transfer_count != 3'b111); // [RULE9]
  wire start_det = det_en & scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = det_en & scl_s & scl_d & ~sda_d & sda_s;
  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;

  // ----------------------------------------
  // Byte framing and address compare
  // ----------------------------------------
  wire [3:0] nbits = (addr_phase || bits_per_transfer_count == 3'b000) ? 4'd8 :
    {1'b0, bits_per_transfer_count}; // [RULE7] [RULE8]
  wire [3:0] total = nbits + {3'b000, acknowledge_clock_enable}; // [RULE5]
  wire data_slot = bit_idx < nbits;
  wire [7:0] new_byte = {shift_reg[6:0], sda_s}; // [RULE20]
  wire hit7 = new_byte[7:1] == own_address_reg[7:1]; // [RULE1] [RULE12]
  wire hit10 = new_byte == own_address_reg; // [RULE12]
  wire gcall = new_byte == 8'h00;
  wire addr_ok = (ten_bit_address_select ? hit10 : hit7) | gcall; // [RULE11]
  wire lost_now = controller_role & transfer_direction & data_slot & shift_reg[7] & ~sda_s;
  wire [15:0] divp1 = {11'h000, scl_divider_field} + 16'h0001;
  wire [15:0] half = high_speed_select ? (divp1 << `SCL_SH_HS) :
    (divp1 << `SCL_SH_STD); // [RULE2] [RULE22]
  wire [15:0] hold_c = high_speed_select ? HOLD_HS[15:0] : HOLD_STD[15:0]; // [RULE2]
  wire [15:0] setup_c = high_speed_select ? SETUP_HS[15:0] : SETUP_STD[15:0];

  // ----------------------------------------
  // Registers and protocol engine
  // ----------------------------------------
  always @(posedge CLK) begin
    if (!NRST) begin
      shift_reg <= `RST_BYTE; // [RULE23]
      own_address_reg <= `RST_BYTE;
      serial_clock_control_reg <= `RST_BYTE;
      transfer_control_reg <= `RST_BYTE;
      {controller_role, transfer_direction, bus_busy_flag, byte_done_request,
        arbitration_lost_flag, own_address_match_flag, broadcast_hit_flag,
        last_received_bit} <= `RST_STATUS;
      bit_idx <= 4'd0;
      addr_phase <= 1'b0;
      active <= 1'b0;
      done_pend <= 1'b0;
      quiet <= 1'b0;
      ack_low <= 1'b0;
      m_run <= 1'b0;
      scl_rel <= 1'b1;
      gen_state <= G_IDLE;
      cnt <= 16'h0000;
      IRQ <= 1'b0;
    end else begin
      IRQ <= 1'b0;
      // Software side first, so that hardware events below win a same-cycle clash.
      if (wr & (PADDR == `OFS_ADDR)) begin
        own_address_reg <= wd; // [RULE1]
      end
      if (wr & (PADDR == `OFS_CTL)) begin
        transfer_control_reg <= wd;
      end
      if (wr & (PADDR == `OFS_CLKCTL)) begin
        serial_clock_control_reg <= wd;
        cnt <= 16'h0000; // [RULE6]
        scl_rel <= 1'b1; // [RULE6]
      end
      if (wr_data) begin
        shift_reg <= wd;
        byte_done_request <= 1'b1;
        last_received_bit <= 1'b0; // [RULE14]
        own_address_match_flag <= 1'b0; // [RULE16]
        bit_idx <= 4'd0;
        done_pend <= 1'b0;
        if (wr_shift & controller_role) begin
          m_run <= 1'b1;
          scl_rel <= 1'b0;
          cnt <= 16'h0000;
        end
      end
      if (wr_status) begin
        if (wd[`ST_PIN]) begin
          byte_done_request <= 1'b1;
        end
        controller_role <= wd[`ST_MST]; // [RULE13]
        transfer_direction <= wd[`ST_TRX];
        if (interface_enable & wd[`ST_MST] & wd[`ST_TRX] & wd[`ST_BB]) begin
          if (bus_busy_flag) begin
            // A second START while the bus is taken is suppressed.
            controller_role <= 1'b0;
            transfer_direction <= 1'b0;
          end else begin
            gen_state <= G_START;
            cnt <= 16'h0000;
          end
        end else if (interface_enable & wd[`ST_MST] & wd[`ST_TRX] & bus_busy_flag) begin
          gen_state <= G_STOP1;
          cnt <= 16'h0000;
        end
      end

      // Master SCL generation; a stretched SCL pauses the high half.
      if (m_run & gen_state == G_IDLE) begin
        if (scl_rel) begin
          if (scl_s) begin
            cnt <= cnt + 16'h0001;
          end
          if (cnt >= half) begin
            scl_rel <= 1'b0;
            cnt <= 16'h0000;
          end
        end else if (cnt >= half) begin
          scl_rel <= 1'b1;
          cnt <= 16'h0000;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end

      case (gen_state)
        G_IDLE: begin
        end
        G_START: begin
          cnt <= cnt + 16'h0001;
          if (cnt >= hold_c) begin
            gen_state <= G_IDLE;
            m_run <= 1'b1;
            scl_rel <= 1'b0;
            cnt <= 16'h0000;
          end
        end
        G_STOP1: begin
          cnt <= cnt + 16'h0001;
          if (cnt >= half) begin
            gen_state <= G_STOP2;
            cnt <= 16'h0000;
          end
        end
        G_STOP2: begin
          if (scl_s) begin
            cnt <= cnt + 16'h0001;
          end
          if (cnt >= setup_c) begin
            gen_state <= G_IDLE;
            m_run <= 1'b0;
            scl_rel <= 1'b1;
            cnt <= 16'h0000;
          end
        end
        default: begin
          gen_state <= G_IDLE;
        end
      endcase

      // Bit sampling on SCL rise.
      if (scl_rise & active & interface_enable) begin
        bit_idx <= bit_idx + 4'd1;
        last_received_bit <= sda_s; // [RULE14]
        if (data_slot) begin
          shift_reg <= new_byte; // [RULE20]
          if (lost_now) begin
            arbitration_lost_flag <= 1'b1; // [RULE18]
            transfer_direction <= 1'b0; // [RULE18] [RULE19]
          end
          if (bit_idx == nbits - 4'd1) begin
            ack_low <= ~acknowledge_drive_level; // [RULE3]
            if (addr_phase & ~free_format_select &
                ~(controller_role & transfer_direction & ~lost_now)) begin
              ack_low <= ~acknowledge_drive_level & addr_ok; // [RULE4]
              quiet <= ~addr_ok; // [RULE11]
              if (addr_ok) begin
                own_address_match_flag <= 1'b1; // [RULE16] [RULE17]
                broadcast_hit_flag <= gcall; // [RULE15]
                if (~ten_bit_address_select) begin
                  transfer_direction <= new_byte[0];
                end
              end
            end
          end
        end else if (~controller_role & transfer_direction & sda_s) begin
          transfer_direction <= 1'b0;
        end
        if (bit_idx + 4'd1 == total) begin
          done_pend <= 1'b1;
        end
      end

      // Byte end on the falling edge of its last clock.
      if (scl_fall & done_pend) begin
        done_pend <= 1'b0;
        bit_idx <= 4'd0;
        addr_phase <= 1'b0;
        m_run <= 1'b0;
        quiet <= 1'b0;
        if (arbitration_lost_flag) begin
          controller_role <= 1'b0; // [RULE18]
        end
        if (quiet) begin
          active <= 1'b0; // [RULE11]
        end else begin
          byte_done_request <= 1'b0; // [RULE7] [RULE21]
          IRQ <= 1'b1; // [RULE21]
        end
      end

      if (start_det) begin
        bus_busy_flag <= 1'b1;
        transfer_control_reg[2:0] <= 3'b000; // [RULE8]
        addr_phase <= 1'b1;
        active <= 1'b1;
        bit_idx <= 4'd0;
        done_pend <= 1'b0;
        quiet <= 1'b0;
        broadcast_hit_flag <= 1'b0; // [RULE15]
        if (~controller_role) begin
          transfer_direction <= 1'b0;
        end
      end
      if (stop_det) begin
        bus_busy_flag <= 1'b0;
        broadcast_hit_flag <= 1'b0; // [RULE15]
        controller_role <= 1'b0;
        transfer_direction <= 1'b0;
        own_address_reg[0] <= 1'b0;
        active <= 1'b0;
        addr_phase <= 1'b0;
        done_pend <= 1'b0;
        m_run <= 1'b0;
        if (~controller_role) begin
          IRQ <= 1'b1;
        end
      end

      if (~interface_enable) begin
        byte_done_request <= 1'b1; // [RULE10]
        bus_busy_flag <= 1'b0; // [RULE10]
        arbitration_lost_flag <= 1'b0; // [RULE10]
        gen_state <= G_IDLE;
        m_run <= 1'b0;
        active <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Data and ack bits change SDA only while SCL is low, so a data change never looks like a condition.
  always @(posedge CLK) begin
    if (!NRST) begin
      data_low <= 1'b0;
    end else if (~scl_s) begin
      if (~active | ~byte_done_request | quiet) begin
        data_low <= 1'b0;
      end else if (data_slot) begin
        data_low <= transfer_direction & ~shift_reg[7]; // [RULE20]
      end else begin
        data_low <= ~transfer_direction & ack_low; // [RULE3] [RULE5]
      end
    end
  end

  always @(posedge CLK) begin
    if (!NRST) begin
      SDA_OE <= 1'b0;
      SCL_OE <= 1'b0;
    end else begin
      SDA_OE <= interface_enable & (data_low | gen_state != G_IDLE); // [RULE10]
      SCL_OE <= interface_enable & ((gen_state == G_IDLE & ~byte_done_request & bus_busy_flag) |
        (gen_state == G_IDLE & m_run & ~scl_rel) | gen_state == G_STOP1); // [RULE21]
    end
  end

  assign SDA_OUT = 1'b0;
  assign SCL_OUT = 1'b0;

endmodule // multi_master_i2c_regs

// ### verif/i2c_regs_checker_properties.sv
// Concurrent checks on the ports of the two-wire controller.
// Assumes a bind onto multi_master_i2c_regs; sees its ports only.
`timescale 1ns/1ps
`include "i2c_ctl_regs.vh"
module i2c_regs_checker (
  input wire CLK,
  input wire NRST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [7:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire PREADY,
  input wire PSLVERR,
  input wire SCL_IN,
  input wire SCL_OUT,
  input wire SCL_OE,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire IRQ
);
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // Shadow of the enable bit, so reads can be judged without the body.
  logic enable_reg;
  wire acc = PSEL && PENABLE;
  wire rd = acc && !PWRITE;
  wire ctl_wr = acc && PWRITE && PADDR == `OFS_CTL;
  always @(posedge CLK) begin
    if (!NRST) enable_reg <= 1'b0;
    else if (ctl_wr) enable_reg <= PWDATA[`CT_ESO];
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ready_always: assert property (PREADY) else $error("wait state seen");
  a_err_unmapped: assert property (acc && PADDR > `OFS_TXBUF |-> PSLVERR)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (acc && PADDR <= `OFS_TXBUF && PADDR[1:0] == 2'b00 |-> !PSLVERR)
    else $error("error on mapped address");
  a_err_access_only: assert property (PSLVERR |-> acc) else $error("error outside access");
  a_pins_open_drain: assert property (!SCL_OUT && !SDA_OUT) else $error("pin driven high");
  a_irq_single: assert property (IRQ |=> !IRQ) else $error("request longer than a cycle");
  a_reset_quiet: assert property ($rose(NRST) |-> !IRQ && !SCL_OE && !SDA_OE && PRDATA == 32'h0)
    else $error("outputs not idle after reset");
  a_disable_release: assert property (ctl_wr && !PWDATA[`CT_ESO] |=> ##[0:3] !SCL_OE && !SDA_OE)
    else $error("pins not released when disabled");
  a_status_disabled: assert property (rd && PADDR == `OFS_STATUS && !enable_reg &&
    !$past(enable_reg, 4) |-> PRDATA[5:3] == 3'b010) else $error("disabled status wrong");
  a_rdata_upper: assert property (rd |-> PRDATA[31:8] == 24'h0) else $error("upper read bits set");
  a_rdata_stable: assert property (acc |=> $stable(PRDATA)) else $error("read data moved");
  a_txbuf_reads_zero: assert property (rd && PADDR >= `OFS_TXBUF |-> PRDATA == 32'h0)
    else $error("write-only or unmapped read not zero");
  c_irq: cover property (IRQ);
  c_slverr: cover property (PSLVERR);
  c_ack_drive: cover property ($rose(SDA_OE));
  c_scl_hold: cover property ($rose(SCL_OE));
endmodule // i2c_regs_checker

// ### verif/i2c_bus_master_model.sv
// Behavioural far-side master on the two-wire bus.
// Assumes the bench resolves the wires with pull-ups from all pull enables.
`timescale 1ns/1ps
module i2c_bus_master_model (
  input wire scl,
  input wire sda,
  output reg scl_pull,
  output reg sda_pull
);
  localparam integer HALF = 24;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end
  // One clock; waits while the slave stretches SCL, as a real master must.
  task automatic pulse(output logic s);
    #(HALF / 2) scl_pull = 1'b0;
    wait (scl === 1'b1);
    s = sda;
    #HALF scl_pull = 1'b1;
    #(HALF / 2);
  endtask
  task automatic frame(input logic [7:0] b, output logic ack);
    integer i;
    logic s;
    sda_pull = 1'b1;
    #HALF scl_pull = 1'b1;
    for (i = 7; i >= 0; i--) begin
      sda_pull = !b[i];
      pulse(s);
    end
    sda_pull = 1'b0;
    pulse(ack);
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    #(HALF / 2) scl_pull = 1'b0;
    wait (scl === 1'b1);
    #HALF sda_pull = 1'b0;
    #(2 * HALF);
  endtask
endmodule // i2c_bus_master_model

// ### verif/multi_master_i2c_regs_bench.sv
// Self-checking bench: APB register access and slave address handling.
// Assumes the far-side master model and the checker beside the design.
`timescale 1ns/1ps
`include "i2c_ctl_regs.vh"
module multi_master_i2c_regs_bench;
  logic CLK, NRST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, rerr;
  logic SCL_OUT, SCL_OE, SDA_OUT, SDA_OE, scl_pull, sda_pull, scl_w, sda_w;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rdata;
  integer errors = 0;
  integer num_checks = 0;
  integer irq_cnt = 0;
  integer cycles = 0;
  assign scl_w = !(SCL_OE || scl_pull);
  assign sda_w = !(SDA_OE || sda_pull);
  multi_master_i2c_regs dut_u (.CLK(CLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .SCL_IN(scl_w), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE), .SDA_IN(sda_w),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .IRQ(IRQ));
  i2c_bus_master_model partner_u (.scl(scl_w), .sda(sda_w), .scl_pull(scl_pull),
    .sda_pull(sda_pull));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task end_sim();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge CLK) begin
    cycles = cycles + 1;
    if (IRQ === 1'b1) irq_cnt = irq_cnt + 1;
    if (cycles == 40000) begin
      errors = errors + 1;
      $display("mismatch at %0t: run timed out", $time);
      end_sim();
    end
  end
  task cmp8(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task cmp1(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: %s got %b exp %b", $time, msg, got, exp);
    end
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= {24'h000000, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rdata = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task rd_cmp(input logic [7:0] a, input logic [7:0] exp, input string msg);
    apb(1'b0, a, 8'h00);
    cmp8(rdata[7:0], exp, msg);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset();
    rd_cmp(`OFS_SHIFT, 8'h00, "shift reset");
    rd_cmp(`OFS_ADDR, 8'h00, "address reset");
    rd_cmp(`OFS_CLKCTL, 8'h00, "clock control reset");
    rd_cmp(`OFS_CTL, 8'h00, "control reset");
    rd_cmp(`OFS_STATUS, 8'h10, "status reset");
    rd_cmp(8'h20, 8'h00, "unmapped read");
    cmp1(rerr, 1'b1, "unmapped error");
    $display("test reset done");
  endtask
  task t_disabled();
    apb(1'b1, `OFS_CTL, 8'h00);
    apb(1'b1, `OFS_SHIFT, 8'h5A);
    rd_cmp(`OFS_SHIFT, 8'h00, "shift write while off");
    $display("test disabled done");
  endtask
  task t_regs();
    // Clock control is only written with the bus idle.
    apb(1'b1, `OFS_CLKCTL, 8'hBF);
    rd_cmp(`OFS_CLKCTL, 8'hBF, "clock control");
    apb(1'b1, `OFS_CLKCTL, 8'h80);
    apb(1'b1, `OFS_CTL, 8'h08);
    apb(1'b1, `OFS_STATUS, 8'h1F);
    rd_cmp(`OFS_STATUS, 8'h10, "read-only status bits");
    apb(1'b1, `OFS_ADDR, 8'hA4);
    rd_cmp(`OFS_ADDR, 8'hA4, "own address");
    $display("test registers done");
  endtask
  task slave_case(input logic [7:0] b, input logic eack, input integer eirq,
    input logic [7:0] mask, input logic [7:0] est);
    integer n;
    logic ack;
    n = irq_cnt;
    partner_u.frame(b, ack);
    cmp1(ack, eack, "address ack");
    repeat (20) @(posedge CLK);
    cmp1(irq_cnt - n == eirq, 1'b1, "byte request");
    cmp1(SCL_OE, eirq == 1, "clock held after byte");
    apb(1'b0, `OFS_STATUS, 8'h00);
    cmp8(rdata[7:0] & mask, est, "status after address");
    if (eirq == 1) begin
      rd_cmp(`OFS_SHIFT, b, "received byte");
    end
    apb(1'b1, `OFS_SHIFT, 8'hFF);
    partner_u.stop();
    repeat (20) @(posedge CLK);
    rd_cmp(`OFS_STATUS, 8'h10, "status after stop");
    cmp1(irq_cnt - n == eirq + 1, 1'b1, "stop request");
  endtask
  task t_seven_bit();
    slave_case(8'hA4, 1'b0, 1, 8'h37, 8'h24);
    slave_case(8'hB0, 1'b1, 0, 8'h37, 8'h31);
    slave_case(8'h00, 1'b0, 1, 8'h37, 8'h26);
    apb(1'b1, `OFS_CLKCTL, 8'hC0);
    slave_case(8'hA4, 1'b1, 1, 8'h37, 8'h25);
    apb(1'b1, `OFS_CLKCTL, 8'h80);
    apb(1'b1, `OFS_CTL, 8'h18);
    slave_case(8'hB0, 1'b0, 1, 8'h37, 8'h20);
    $display("test seven bit done");
  endtask
  task t_ten_bit();
    apb(1'b1, `OFS_CTL, 8'h28);
    apb(1'b1, `OFS_ADDR, 8'hA5);
    slave_case(8'hA5, 1'b0, 1, 8'h37, 8'h24);
    apb(1'b1, `OFS_ADDR, 8'hA5);
    slave_case(8'hA4, 1'b1, 0, 8'h37, 8'h31);
    $display("test ten bit done");
  endtask
  initial begin
    NRST = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h00000000;
    repeat (12) @(posedge CLK);
    NRST <= 1'b1;
    t_reset();
    t_disabled();
    t_regs();
    t_seven_bit();
    t_ten_bit();
    end_sim();
  end
endmodule // multi_master_i2c_regs_bench
bind multi_master_i2c_regs i2c_regs_checker chk_u (.CLK(CLK), .NRST(NRST), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .IRQ(IRQ));
